// *** core/fid_feature_identification.sv ***
// Feature identification register, bits 19 down to 5, with read port
`timescale 1ns/1ps
`default_nettype none

// Function
// R1 - Bit 19 reports two-level context tables
// R2 - Bit 18 clear: upper VM tag bits zero
// R3 - Bit 17 wildcard; zero without stage two
// R4 - Bit 16 page requests; zero without ATS
// R5 - Bit 15 translation ops; else virtual page zero
// R6 - Bit 14 only if wake-ups reach all
// R7 - Bit 13 message interrupts; else fields zero
// R8 - Bit 12 clear: upper space tag bits zero
// R9 - Bit 11 split-stage unsupported; needs ATS, both
// R10 - Bit 10 reports unit ATS support
// R11 - Bit 9 hypervisor contexts; needs both stages
// R12 - Later revisions with both stages: bit 9 one
// R13 - Hypervisor contexts recommended with both stages
// R14 - Bit 8 reports dormant hint support
// R15 - Bits 7:6 hardware update encoding, 11 reserved
// R16 - Hardware update none without coherent atomics
// R17 - Bit 5 needs unit, system, interconnect
// R18 - Read-only register at offset zero
// R19 - Fixed values from reset; writes ignored
module fid_feature_identification
    import fid_pkg::*;
#(
    parameter bit       CAP_TWO_LEVEL_CT   = 1'b1,  // Unit has two-level tables
    parameter bit       CAP_WIDE_VM_TAG    = 1'b1,  // Unit has 16-bit VM tags
    parameter bit       CAP_VM_WILDCARD    = 1'b1,  // Unit can wildcard VM tags
    parameter bit       CAP_PAGE_REQUEST   = 1'b1,  // Unit has page requests
    parameter bit       CAP_XLAT_OPS       = 1'b1,  // Unit has translation ops
    parameter bit       CAP_VIRT_XLAT_PAGE = 1'b0,  // Unit has the virtual op page
    parameter bit       CAP_WAKEUP_EVENT   = 1'b1,  // Unit can raise wake-ups
    parameter bit       CAP_MSG_IRQ        = 1'b1,  // Unit has message interrupts
    parameter bit       CAP_WIDE_SPACE_TAG = 1'b1,  // Unit has 16-bit space tags
    parameter bit       CAP_NO_SPLIT_STAGE = 1'b0,  // Unit lacks split-stage service
    parameter bit       CAP_XLAT_SERVICE   = 1'b1,  // Unit has translation services
    parameter bit       CAP_HYP_CONTEXT    = 1'b1,  // Unit tags hypervisor contexts
    parameter bit       CAP_DORMANT_HINT   = 1'b0,  // Unit has dormant hint
    parameter bit [1:0] CAP_HW_UPDATE      = 2'h2,  // Unit hardware update level
    parameter bit       CAP_BROADCAST      = 1'b1,  // Unit accepts broadcasts
    parameter bit       STAGE_ONE_PRESENT  = 1'b1,  // stage_one_present
    parameter bit       STAGE_TWO_PRESENT  = 1'b1,  // stage_two_present
    parameter bit       LATER_REVISION     = 1'b1   // Revision needing hypervisor bit
)
(
    input  wire logic               ref_clk_i,            // System clock, 100 MHz
    input  wire logic               srst_i,               // Synchronous reset, active high
    input  wire logic               rd_req_i,             // Register read strobe
    input  wire logic               wr_req_i,             // Register write strobe
    input  wire logic [ADDR_W-1:0]  addr_i,               // Register byte address
    input  wire logic [DATA_W-1:0]  wdata_i,              // Write data, discarded
    input  wire logic [STRAP_W-1:0] sys_strap_i,          // System capability straps
    output logic                    ack_o,                // Access answered, one cycle
    output logic      [DATA_W-1:0]  rdata_o,              // Read data with ack
    output logic                    virt_xlat_op_page_o,  // virtual_translation_op_page
    output logic                    xlat_op_regs_o,       // Translation-op registers live
    output logic                    page_req_regs_o,      // Page-request registers live
    output logic                    msg_irq_fields_o,     // Message irq fields live
    output logic                    vm_tag_upper_ok_o,    // Upper VM tag bits usable
    output logic                    space_tag_upper_ok_o  // Upper space tag bits usable
);
    logic [STRAP_W-1:0] strap;       // Straps frozen at reset release
    logic [DATA_W-1:0]  word_d;      // Resolved register word
    logic [DATA_W-1:0]  word_q;      // Registered register word
    logic [5:0]         gate_d;      // Next derived enables
    logic [5:0]         gate_q;      // Registered derived enables
    logic               ats_ok;      // Translation services present
    logic               both_stages; // Both stages present
    logic               wake_ok;     // Wake-ups reach every processor
    logic               hw_sys_ok;   // System carries coherent atomics
    logic               bcast_ok;    // Broadcast supported end to end
    logic [1:0]         hw_level;    // Qualified hardware update level
    logic               hyp_bit;     // Qualified hypervisor bit
    logic               unused_wr;   // Sink for discarded write data

    fid_word_if word_if ();          // Carrier to the read port

    // Freeze system straps so the word is constant after reset
    fid_strap_capture u_strap (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .strap_i   (sys_strap_i),
        .strap_o   (strap)
    );

    // Write data has no destination in a read-only register
    assign unused_wr = ^wdata_i;  // R19

    // Prerequisite terms shared by several fields
    always_comb begin
        ats_ok      = CAP_XLAT_SERVICE;                            // R10
        both_stages = STAGE_ONE_PRESENT & STAGE_TWO_PRESENT;
        wake_ok     = CAP_WAKEUP_EVENT & strap[STRAP_WAKEUP];      // R6
        hw_sys_ok   = strap[STRAP_COH_ATOMIC];                     // R16
        bcast_ok    = CAP_BROADCAST & strap[STRAP_BCAST_SYS]
                    & strap[STRAP_BCAST_ICN];                      // R17
        // Hypervisor bit: optional, forced in later revisions
        if (!both_stages) begin
            hyp_bit = 1'b0;                                        // R11
        end else if (LATER_REVISION) begin
            hyp_bit = 1'b1;                                        // R12
        end else begin
            hyp_bit = CAP_HYP_CONTEXT;                             // R13
        end
        // Hardware update level, reserved code never reported
        if (!hw_sys_ok) begin
            hw_level = HW_UPD_NONE;                                // R16
        end else if (CAP_HW_UPDATE == HW_UPD_RESERVED) begin
            hw_level = HW_UPD_NONE;                                // R15
        end else begin
            hw_level = CAP_HW_UPDATE;                              // R15
        end
    end

    // Assemble the register word; unlisted bits read zero
    always_comb begin
        word_d                     = RESET_WORD;
        word_d[BIT_TWO_LEVEL_CT]   = CAP_TWO_LEVEL_CT;                      // R1
        word_d[BIT_WIDE_VM_TAG]    = CAP_WIDE_VM_TAG;                       // R2
        word_d[BIT_VM_WILDCARD]    = CAP_VM_WILDCARD & STAGE_TWO_PRESENT;   // R3
        word_d[BIT_PAGE_REQUEST]   = CAP_PAGE_REQUEST & ats_ok;             // R4
        word_d[BIT_XLAT_OPS]       = CAP_XLAT_OPS;                          // R5
        word_d[BIT_WAKEUP_EVENT]   = wake_ok;                               // R6
        word_d[BIT_MSG_IRQ]        = CAP_MSG_IRQ;                           // R7
        word_d[BIT_WIDE_SPACE_TAG] = CAP_WIDE_SPACE_TAG;                    // R8
        word_d[BIT_SPLIT_UNSUP]    = CAP_NO_SPLIT_STAGE & ats_ok
                                   & both_stages;                           // R9
        word_d[BIT_XLAT_SERVICE]   = ats_ok;                                // R10
        word_d[BIT_HYP_CONTEXT]    = hyp_bit;                               // R11
        word_d[BIT_DORMANT_HINT]   = CAP_DORMANT_HINT;                      // R14
        word_d[BIT_HW_UPDATE_HI:BIT_HW_UPDATE_LO] = hw_level;               // R15
        word_d[BIT_BROADCAST]      = bcast_ok;                              // R17
    end

    // Enables derived from the word for neighbouring blocks
    always_comb begin
        gate_d[0] = CAP_VIRT_XLAT_PAGE & word_d[BIT_XLAT_OPS]
                  & both_stages;                                   // R5
        gate_d[1] = word_d[BIT_XLAT_OPS];                          // R5
        gate_d[2] = word_d[BIT_PAGE_REQUEST];                      // R4
        gate_d[3] = word_d[BIT_MSG_IRQ];                           // R7
        gate_d[4] = word_d[BIT_WIDE_VM_TAG];                       // R2
        gate_d[5] = word_d[BIT_WIDE_SPACE_TAG];                    // R8
    end

    // Register word and enables; constant from first edge after reset
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            word_q <= RESET_WORD;
            gate_q <= 6'h00;
        end else begin
            word_q <= word_d;                                      // R19
            gate_q <= gate_d;
        end
    end

    assign word_if.word = word_q;

    // Read-only answer at offset zero
    fid_read_port u_port (  // R18
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .rd_req_i  (rd_req_i),
        .wr_req_i  (wr_req_i),
        .addr_i    (addr_i),
        .word_if   (word_if),
        .ack_o     (ack_o),
        .rdata_o   (rdata_o)
    );

    // Enable outputs straight from flops
    assign virt_xlat_op_page_o  = gate_q[0];
    assign xlat_op_regs_o       = gate_q[1];
    assign page_req_regs_o      = gate_q[2];
    assign msg_irq_fields_o     = gate_q[3];
    assign vm_tag_upper_ok_o    = gate_q[4];
    assign space_tag_upper_ok_o = gate_q[5];
endmodule : fid_feature_identification
`default_nettype wire

// *** core/fid_pkg.sv ***
// Package of constants for the feature identification register bank
package fid_pkg;
    // Register bus geometry
    localparam int unsigned        ADDR_W        = 16;          // Byte address width
    localparam int unsigned        DATA_W        = 32;          // Register width
    localparam logic [ADDR_W-1:0]  OFS_FEAT_ID_0 = 16'h0000;    // feature_identification_0
    localparam logic [DATA_W-1:0]  RESET_WORD    = 32'h0000_0000; // Value held in reset

    // Field positions inside feature_identification_0
    localparam int unsigned BIT_TWO_LEVEL_CT   = 19;  // two_level_context_table_support
    localparam int unsigned BIT_WIDE_VM_TAG    = 18;  // wide_vm_tag_support
    localparam int unsigned BIT_VM_WILDCARD    = 17;  // vm_tag_wildcard_invalidate
    localparam int unsigned BIT_PAGE_REQUEST   = 16;  // page_request_support
    localparam int unsigned BIT_XLAT_OPS       = 15;  // translation_operations_support
    localparam int unsigned BIT_WAKEUP_EVENT   = 14;  // wakeup_event_support
    localparam int unsigned BIT_MSG_IRQ        = 13;  // Message interrupt support
    localparam int unsigned BIT_WIDE_SPACE_TAG = 12;  // wide_space_tag_support
    localparam int unsigned BIT_SPLIT_UNSUP    = 11;  // split_stage_xlat_unsupported
    localparam int unsigned BIT_XLAT_SERVICE   = 10;  // Address translation services
    localparam int unsigned BIT_HYP_CONTEXT    = 9;   // Hypervisor context support
    localparam int unsigned BIT_DORMANT_HINT   = 8;   // dormant_hint_support
    localparam int unsigned BIT_HW_UPDATE_HI   = 7;   // hw_table_update_support, top
    localparam int unsigned BIT_HW_UPDATE_LO   = 6;   // hw_table_update_support, bottom
    localparam int unsigned BIT_BROADCAST      = 5;   // broadcast_maintenance_support

    // Encodings of hw_table_update_support
    localparam logic [1:0] HW_UPD_NONE       = 2'h0;  // No hardware updates
    localparam logic [1:0] HW_UPD_ACCESS     = 2'h1;  // Access flag only
    localparam logic [1:0] HW_UPD_ACC_DIRTY  = 2'h2;  // Access flag and dirty state
    localparam logic [1:0] HW_UPD_RESERVED   = 2'h3;  // Reserved, never reported

    // System strap vector layout
    localparam int unsigned STRAP_W           = 4;   // Number of system straps
    localparam int unsigned STRAP_WAKEUP      = 0;   // System delivers wake-up events
    localparam int unsigned STRAP_COH_ATOMIC  = 1;   // System has coherent atomics
    localparam int unsigned STRAP_BCAST_SYS   = 2;   // System supports broadcast
    localparam int unsigned STRAP_BCAST_ICN   = 3;   // Interconnect supports broadcast
endpackage : fid_pkg

// *** core/fid_word_if.sv ***
// Interface carrying the resolved identification word to the read port
`timescale 1ns/1ps
`default_nettype none
interface fid_word_if;
    import fid_pkg::*;
    logic [DATA_W-1:0] word;   // Resolved register contents
    modport src (output word); // Field resolver side
    modport dst (input  word); // Read port side
endinterface : fid_word_if
`default_nettype wire

// *** core/fid_strap_capture.sv ***
// Capture of system capability straps while reset is asserted
`timescale 1ns/1ps
`default_nettype none
module fid_strap_capture
    import fid_pkg::*;
(
    input  wire logic               ref_clk_i,  // System clock
    input  wire logic               srst_i,     // Synchronous reset, active high
    input  wire logic [STRAP_W-1:0] strap_i,    // Live system straps
    output logic      [STRAP_W-1:0] strap_o     // Straps frozen at reset release
);
    logic [STRAP_W-1:0] strap_d;  // Next captured value
    logic [STRAP_W-1:0] strap_q;  // Captured value

    // Follow the straps during reset, hold them afterwards
    always_comb begin
        if (srst_i) begin
            strap_d = strap_i;
        end else begin
            strap_d = strap_q;
        end
    end

    // Register the captured straps
    always_ff @(posedge ref_clk_i) begin
        strap_q <= strap_d;
    end

    assign strap_o = strap_q;
endmodule : fid_strap_capture
`default_nettype wire

// *** core/fid_read_port.sv ***
// Read-only register port answering at the identification offset
`timescale 1ns/1ps
`default_nettype none
module fid_read_port
    import fid_pkg::*;
(
    input  wire logic              ref_clk_i,  // System clock
    input  wire logic              srst_i,     // Synchronous reset, active high
    input  wire logic              rd_req_i,   // Read request strobe
    input  wire logic              wr_req_i,   // Write request strobe
    input  wire logic [ADDR_W-1:0] addr_i,     // Byte address in the page
    fid_word_if.dst                word_if,    // Resolved identification word
    output logic                   ack_o,      // Access answered, one cycle
    output logic      [DATA_W-1:0] rdata_o     // Read data, valid with ack
);
    logic              ack_d;    // Next acknowledge
    logic              ack_q;    // Registered acknowledge
    logic [DATA_W-1:0] rdata_d;  // Next read data
    logic [DATA_W-1:0] rdata_q;  // Registered read data

    // Decode the access; writes are answered and discarded
    always_comb begin
        ack_d   = rd_req_i | wr_req_i;
        rdata_d = RESET_WORD;
        if (rd_req_i && (addr_i == OFS_FEAT_ID_0)) begin
            rdata_d = word_if.word;  // R18
        end
    end

    // Register the answer
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= RESET_WORD;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign ack_o   = ack_q;
    assign rdata_o = rdata_q;
endmodule : fid_read_port
`default_nettype wire

// *** test/fid_feature_identification_props.sv ***
// Assertion checker for the feature identification register port
`timescale 1ns/1ps
`default_nettype none
module fid_feature_identification_props
    import fid_pkg::*;
(
    input wire logic               ref_clk_i,            // System clock
    input wire logic               srst_i,               // Synchronous reset
    input wire logic               rd_req_i,             // Read strobe
    input wire logic               wr_req_i,             // Write strobe
    input wire logic [ADDR_W-1:0]  addr_i,               // Byte address
    input wire logic [DATA_W-1:0]  wdata_i,              // Write data
    input wire logic [STRAP_W-1:0] sys_strap_i,          // System straps
    input wire logic               ack_o,                // Access answered
    input wire logic [DATA_W-1:0]  rdata_o,              // Read data
    input wire logic               virt_xlat_op_page_o,  // Virtual op page
    input wire logic               xlat_op_regs_o,       // Translation-op regs
    input wire logic               page_req_regs_o,      // Page-request regs
    input wire logic               msg_irq_fields_o,     // Message irq fields
    input wire logic               vm_tag_upper_ok_o,    // Upper VM tag bits
    input wire logic               space_tag_upper_ok_o  // Upper space tag bits
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    logic rd0;  // Read aimed at the mapped word
    assign rd0 = rd_req_i && (addr_i == OFS_FEAT_ID_0);
    // Two reads of the word in a row
    sequence s_two_reads;
        rd0 ##1 rd0;
    endsequence
    chk_ack_follows_req: assert property ((rd_req_i || wr_req_i) |=> ack_o)
        else $error("access not answered next cycle");
    chk_no_spurious_ack: assert property (!(rd_req_i || wr_req_i) |=> !ack_o)
        else $error("answer without access");
    chk_rdata_zero_other: assert property (!rd0 |=> rdata_o == '0)
        else $error("read data not zero outside a word read");
    chk_word_stable: assert property (s_two_reads |=> $stable(rdata_o))
        else $error("identification word changed");
    chk_reserved_zero: assert property (ack_o |-> rdata_o[31:20] == '0 && rdata_o[4:0] == '0)
        else $error("bits outside the field range set");
    chk_hw_upd_legal: assert property (ack_o |-> rdata_o[7:6] != HW_UPD_RESERVED)
        else $error("reserved hardware update encoding");
    chk_ats_gating: assert property (ack_o && (rdata_o[16] || rdata_o[11]) |-> rdata_o[10])
        else $error("field set without translation services");
    chk_enables_track: assert property (ack_o && $past(rd0) |->
        {xlat_op_regs_o, page_req_regs_o, msg_irq_fields_o} == {rdata_o[15], rdata_o[16], rdata_o[13]})
        else $error("register enables differ from word");
    chk_tag_enables: assert property (ack_o && $past(rd0) |->
        vm_tag_upper_ok_o == rdata_o[18] && space_tag_upper_ok_o == rdata_o[12])
        else $error("tag enables differ from word");
    chk_virt_page_gated: assert property (virt_xlat_op_page_o |-> xlat_op_regs_o)
        else $error("virtual op page without translation ops");
    chk_quiet_reset: assert property (disable iff (1'b0) srst_i |=> !ack_o && rdata_o == '0)
        else $error("port active in reset");
    // Main scenarios
    cover property (rd0 ##1 ack_o);
    cover property (wr_req_i ##1 ack_o);
    cover property (rd_req_i && !rd0 ##1 ack_o);
endmodule // fid_feature_identification_props
bind fid_feature_identification fid_feature_identification_props fid_feature_identification_props_i (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .sys_strap_i(sys_strap_i), .ack_o(ack_o),
    .rdata_o(rdata_o), .virt_xlat_op_page_o(virt_xlat_op_page_o),
    .xlat_op_regs_o(xlat_op_regs_o), .page_req_regs_o(page_req_regs_o),
    .msg_irq_fields_o(msg_irq_fields_o), .vm_tag_upper_ok_o(vm_tag_upper_ok_o),
    .space_tag_upper_ok_o(space_tag_upper_ok_o));
`default_nettype wire

// *** test/fid_feature_identification_bench.sv ***
// Self-checking bench for the feature identification register
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module fid_feature_identification_bench
    import fid_pkg::*;
;
    logic               ref_clk;     // Bench clock
    logic               srst;        // Reset
    logic               rd_req;      // Read strobe
    logic               wr_req;      // Write strobe
    logic [ADDR_W-1:0]  addr;        // Byte address
    logic [DATA_W-1:0]  wdata;       // Write data
    logic [STRAP_W-1:0] strap;       // System straps
    logic               ack;         // Answer
    logic [DATA_W-1:0]  rdata;       // Read data
    logic [5:0]         ens;         // Enable outputs
    logic [DATA_W-1:0]  exp_w;       // Expected word
    int                 err_count;   // Mismatches
    int                 check_count; // Comparisons
    fid_feature_identification fid_feature_identification_i (
        .ref_clk_i(ref_clk), .srst_i(srst), .rd_req_i(rd_req), .wr_req_i(wr_req),
        .addr_i(addr), .wdata_i(wdata), .sys_strap_i(strap), .ack_o(ack), .rdata_o(rdata),
        .virt_xlat_op_page_o(ens[5]), .xlat_op_regs_o(ens[4]), .page_req_regs_o(ens[3]),
        .msg_irq_fields_o(ens[2]), .vm_tag_upper_ok_o(ens[1]), .space_tag_upper_ok_o(ens[0]));
    // Clock, 10 ns period
    always #5 ref_clk = ~ref_clk;
    // Word expected for the default build and given straps
    function automatic logic [DATA_W-1:0] word_for(input logic [STRAP_W-1:0] s);
        logic [DATA_W-1:0] w;
        w = 32'h000fb600;
        w[BIT_WAKEUP_EVENT] = s[STRAP_WAKEUP];
        w[BIT_HW_UPDATE_HI:BIT_HW_UPDATE_LO] = s[STRAP_COH_ATOMIC] ? HW_UPD_ACC_DIRTY : HW_UPD_NONE;
        w[BIT_BROADCAST] = s[STRAP_BCAST_SYS] & s[STRAP_BCAST_ICN];
        return w;
    endfunction
    // Print verdict and stop
    task automatic finish_test();
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One access; strobes stay up so calls run back to back
    task automatic acc(input logic r, input logic w, input logic [ADDR_W-1:0] a);
        rd_req = r;
        wr_req = w;
        addr = a;
        @(posedge ref_clk);
        #1;
    endtask
    // Drop strobes and see the answer fall away
    task automatic idle();
        rd_req = 1'b0;
        wr_req = 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK(ack, 1'b0)
        `CHK(rdata, 32'h0)
    endtask
    // Reset with straps, check quiet ack and enables meanwhile
    task automatic do_reset(input logic [STRAP_W-1:0] s);
        srst = 1'b1;
        strap = s;
        repeat (5) @(posedge ref_clk);
        #1;
        `CHK({ack, ens}, 7'h0)
        srst = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        srst = 1'b1;
        rd_req = 1'b0;
        wr_req = 1'b0;
        addr = '0;
        wdata = 32'hffffffff;
        strap = '0;
        err_count = 0;
        check_count = 0;
        for (int s = 0; s < 16; s++) begin
            do_reset(STRAP_W'(s));
            exp_w = word_for(STRAP_W'(s));
            acc(1'b1, 1'b0, OFS_FEAT_ID_0);
            `CHK(ack, 1'b1)
            `CHK(rdata, exp_w)
            `CHK(ens, 6'h1f)
            strap = ~STRAP_W'(s);
            acc(1'b1, 1'b0, OFS_FEAT_ID_0);
            `CHK(rdata, exp_w)
            idle();
        end
        acc(1'b0, 1'b1, OFS_FEAT_ID_0);
        `CHK({ack, rdata}, {1'b1, 32'h0})
        acc(1'b1, 1'b0, 16'h0004);
        `CHK({ack, rdata}, {1'b1, 32'h0})
        acc(1'b1, 1'b1, OFS_FEAT_ID_0);
        `CHK({ack, rdata}, {1'b1, exp_w})
        idle();
        acc(1'b1, 1'b0, OFS_FEAT_ID_0);
        `CHK(rdata, exp_w)
        idle();
        finish_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
endmodule // fid_feature_identification_bench
`default_nettype wire
